/* inc/ipf_cfg.svh */
// ipf_cfg.svh: named offsets, field positions, reset values and codes
// assumes: included by bare name from the package and every design file
`ifndef IPF_CFG_SVH
`define IPF_CFG_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define IPF_AXI_AW 8
`define IPF_AXI_DW 32
`define IPF_AXI_SW 4
`define IPF_REG_W 16
`define IPF_WORD_LSB 2
`define IPF_LANE_SHIFT 3

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define IPF_OFS_EXT1 8'h00
`define IPF_OFS_SER2 8'h04

// ----------------------------------------------------------------------
// priority fields
// ----------------------------------------------------------------------
`define IPF_FLD_W 3
`define IPF_NUM_SRC 4
`define IPF_LSB_EXT1 0
`define IPF_LSB_EXT2 4
`define IPF_LSB_RX2 8
`define IPF_LSB_TX2 12
`define IPF_SRC_EXT1 0
`define IPF_SRC_EXT2 1
`define IPF_SRC_RX2 2
`define IPF_SRC_TX2 3
`define IPF_PRIO_RST 3'h4
`define IPF_PRIO_OFF 3'h0

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define IPF_RESP_OKAY 2'h0
`define IPF_RESP_DECERR 2'h3
`define IPF_ZERO_WORD 32'h0000_0000

`endif

/* inc/ipf_pkg.sv */
// ipf_pkg.sv: types shared by the priority field bank
// assumes: ipf_cfg.svh is on the include path
`include "ipf_cfg.svh"

package ipf_pkg;

  // --------------------------------------------------------------------
  // data types
  // --------------------------------------------------------------------
  typedef logic [`IPF_FLD_W-1:0] ipf_prio_t;
  typedef logic [`IPF_AXI_AW-1:0] ipf_addr_t;

  typedef struct packed {
    ipf_addr_t addr;
    logic [`IPF_AXI_DW-1:0] data;
    logic [`IPF_AXI_SW-1:0] strb;
  } ipf_wr_cmd_t;

  typedef struct packed {
    logic valid;
    ipf_prio_t level;
  } ipf_req_t;

  // --------------------------------------------------------------------
  // state machines
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    IPF_WR_IDLE = 2'h0,
    IPF_WR_ADDR = 2'h1,
    IPF_WR_RESP = 2'h3,
    IPF_WR_DATA = 2'h2
  } ipf_wr_state_t;

  typedef enum logic {
    IPF_RD_IDLE = 1'h0,
    IPF_RD_RESP = 1'h1
  } ipf_rd_state_t;

endpackage : ipf_pkg

/* rtl/ipf_prio_field.sv */
// ipf_prio_field.sv: one writable priority field with power-on value
// assumes: wrEn is a one-cycle pulse on clk
`timescale 1ns/1ns
`include "ipf_cfg.svh"

module ipf_prio_field
  import ipf_pkg::*;
#(
  parameter int FieldW = `IPF_FLD_W
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [FieldW-1:0] wrVal,
  output logic [FieldW-1:0] prio_q
);

  // reset value and level coding are fixed at three bits
  if (FieldW != `IPF_FLD_W)
  begin : g_check
    $error("ipf_prio_field: FieldW must be three");
  end

  // --------------------------------------------------------------------
  // field storage
  // --------------------------------------------------------------------
  // any code is legal: 0 is off, 1..7 are levels, 7 the highest
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prio_q <= `IPF_PRIO_RST;
    else if (wrEn)
      prio_q <= wrVal;
  end

endmodule : ipf_prio_field

/* rtl/ipf_prio_regs.sv */
// ipf_prio_regs.sv: AXI4-Lite bank of priority fields for four sources
// assumes: one clock, srcPend from the same clock, master per AXI4-Lite
`timescale 1ns/1ns
`include "ipf_cfg.svh"

// Function
// - field code 111 means priority 7, the highest level.
// - code 001 means priority 1; codes between map linearly.
// - code 000 disables the source; it is never presented.
// - external-1 register bits 15..3 always read zero.
// - external-1 field in bits 2..0, read/write, resets to 4.
// - external-2 field in bits 6..4 of second register, resets to 4.
module ipf_prio_regs
  import ipf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`IPF_AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`IPF_AXI_DW-1:0] s_axi_wdata,
  input wire logic [`IPF_AXI_SW-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`IPF_AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`IPF_AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`IPF_NUM_SRC-1:0] srcPend,
  output ipf_prio_t [`IPF_NUM_SRC-1:0] srcPriority,
  output ipf_req_t [`IPF_NUM_SRC-1:0] srcReq,
  output logic anyReq
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // word compare only: the low address bits select a byte, not a register
  function automatic logic ipfHit(ipf_addr_t a, ipf_addr_t ofs);
    ipfHit = a[`IPF_AXI_AW-1:`IPF_WORD_LSB] ==
             ofs[`IPF_AXI_AW-1:`IPF_WORD_LSB];
  endfunction : ipfHit

  function automatic logic ipfMapped(ipf_addr_t a);
    ipfMapped = ipfHit(a, `IPF_OFS_EXT1) || ipfHit(a, `IPF_OFS_SER2);
  endfunction : ipfMapped

  // register that holds a given source
  function automatic ipf_addr_t ipfSrcOfs(int idx);
    ipfSrcOfs = (idx == `IPF_SRC_EXT1) ? `IPF_OFS_EXT1 : `IPF_OFS_SER2;
  endfunction : ipfSrcOfs

  // bit position of a given source's field
  function automatic int ipfSrcLsb(int idx);
    unique case (idx)
      `IPF_SRC_EXT1: ipfSrcLsb = `IPF_LSB_EXT1;
      `IPF_SRC_EXT2: ipfSrcLsb = `IPF_LSB_EXT2;
      `IPF_SRC_RX2: ipfSrcLsb = `IPF_LSB_RX2;
      default: ipfSrcLsb = `IPF_LSB_TX2;
    endcase
  endfunction : ipfSrcLsb

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  ipf_wr_state_t wrState_q;
  ipf_wr_state_t wrState_d;
  ipf_rd_state_t rdState_q;
  ipf_wr_cmd_t wrCmd_q;
  logic wrApply_q;
  logic awReady_q;
  logic wReady_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic arReady_q;
  logic rValid_q;
  logic [1:0] rResp_q;
  logic [`IPF_AXI_DW-1:0] rData_q;
  logic awTake;
  logic wTake;
  logic arTake;
  logic [`IPF_NUM_SRC-1:0] fldWe;
  ipf_prio_t [`IPF_NUM_SRC-1:0] fldWrVal;
  ipf_prio_t [`IPF_NUM_SRC-1:0] fldPrio;
  logic [`IPF_REG_W-1:0] ext1Word;
  logic [`IPF_REG_W-1:0] ser2Word;

  assign awTake = s_axi_awvalid && awReady_q;
  assign wTake = s_axi_wvalid && wReady_q;
  assign arTake = s_axi_arvalid && arReady_q;

  // ----------------------------------------------------------------------
  // write channel state
  // ----------------------------------------------------------------------
  // address and data are taken in either order; the answer follows both
  always_comb
  begin
    wrState_d = wrState_q;
    unique case (wrState_q)
      IPF_WR_IDLE:
      begin
        if (awTake && wTake)
          wrState_d = IPF_WR_RESP;
        else if (awTake)
          wrState_d = IPF_WR_ADDR;
        else if (wTake)
          wrState_d = IPF_WR_DATA;
      end
      IPF_WR_ADDR:
      begin
        if (wTake)
          wrState_d = IPF_WR_RESP;
      end
      IPF_WR_DATA:
      begin
        if (awTake)
          wrState_d = IPF_WR_RESP;
      end
      IPF_WR_RESP:
      begin
        if (s_axi_bready)
          wrState_d = IPF_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrState_q <= IPF_WR_IDLE;
    else
      wrState_q <= wrState_d;
  end

  // readies are registered from the next state so no output is a gate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awReady_q <= 1'b0;
      wReady_q <= 1'b0;
    end
    else
    begin
      awReady_q <= (wrState_d == IPF_WR_IDLE) || (wrState_d == IPF_WR_DATA);
      wReady_q <= (wrState_d == IPF_WR_IDLE) || (wrState_d == IPF_WR_ADDR);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrCmd_q <= '0;
    else
    begin
      if (awTake)
        wrCmd_q.addr <= s_axi_awaddr;
      if (wTake)
      begin
        wrCmd_q.data <= s_axi_wdata;
        wrCmd_q.strb <= s_axi_wstrb;
      end
    end
  end

  // fields change one edge after the answer is raised; a read can not
  // be issued against that write any earlier than the same edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wrApply_q <= 1'b0;
    else
      wrApply_q <= (wrState_q != IPF_WR_RESP) && (wrState_d == IPF_WR_RESP);
  end

  // ----------------------------------------------------------------------
  // write response
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bValid_q <= 1'b0;
      bResp_q <= `IPF_RESP_OKAY;
    end
    else if (wrState_q != IPF_WR_RESP && wrState_d == IPF_WR_RESP)
    begin
      bValid_q <= 1'b1;
      bResp_q <= ipfMapped(awTake ? s_axi_awaddr : wrCmd_q.addr)
                 ? `IPF_RESP_OKAY : `IPF_RESP_DECERR;
    end
    else if (bValid_q && s_axi_bready)
      bValid_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // field write enables
  // ----------------------------------------------------------------------
  // a field moves only when its byte lane is strobed
  always_comb
  begin
    for (int i = 0; i < `IPF_NUM_SRC; i++)
    begin
      fldWe[i] = wrApply_q && ipfHit(wrCmd_q.addr, ipfSrcOfs(i)) &&
                 wrCmd_q.strb[ipfSrcLsb(i) >> `IPF_LANE_SHIFT];
      fldWrVal[i] = wrCmd_q.data[ipfSrcLsb(i) +: `IPF_FLD_W];
    end
  end

  // ----------------------------------------------------------------------
  // priority fields
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < `IPF_NUM_SRC; g++)
  begin : g_fld
    ipf_prio_field #(
      .FieldW(`IPF_FLD_W)
    ) u_fld (
      .clk(clk),
      .rst_n(rst_n),
      .wrEn(fldWe[g]),
      .wrVal(fldWrVal[g]),
      .prio_q(fldPrio[g])
    );
  end

  assign srcPriority = fldPrio;

  // ----------------------------------------------------------------------
  // read-back words
  // ----------------------------------------------------------------------
  // unimplemented bits are held at zero by construction
  always_comb
  begin
    ext1Word = '0;
    ext1Word[`IPF_LSB_EXT1 +: `IPF_FLD_W] = fldPrio[`IPF_SRC_EXT1];
    ser2Word = '0;
    ser2Word[`IPF_LSB_EXT2 +: `IPF_FLD_W] = fldPrio[`IPF_SRC_EXT2];
    ser2Word[`IPF_LSB_RX2 +: `IPF_FLD_W] = fldPrio[`IPF_SRC_RX2];
    ser2Word[`IPF_LSB_TX2 +: `IPF_FLD_W] = fldPrio[`IPF_SRC_TX2];
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdState_q <= IPF_RD_IDLE;
    else
    begin
      unique case (rdState_q)
        IPF_RD_IDLE:
        begin
          if (arTake)
            rdState_q <= IPF_RD_RESP;
        end
        IPF_RD_RESP:
        begin
          if (s_axi_rready)
            rdState_q <= IPF_RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      arReady_q <= 1'b0;
    else if (arTake)
      arReady_q <= 1'b0;
    else
      arReady_q <= !rValid_q || s_axi_rready;
  end

  // unmapped reads answer with zero data and a decode error
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rValid_q <= 1'b0;
      rResp_q <= `IPF_RESP_OKAY;
      rData_q <= `IPF_ZERO_WORD;
    end
    else if (arTake)
    begin
      rValid_q <= 1'b1;
      rData_q <= `IPF_ZERO_WORD;
      rResp_q <= `IPF_RESP_OKAY;
      if (ipfHit(s_axi_araddr, `IPF_OFS_EXT1))
        rData_q[`IPF_REG_W-1:0] <= ext1Word;
      else if (ipfHit(s_axi_araddr, `IPF_OFS_SER2))
        rData_q[`IPF_REG_W-1:0] <= ser2Word;
      else
        rResp_q <= `IPF_RESP_DECERR;
    end
    else if ((rdState_q == IPF_RD_RESP) && s_axi_rready)
      rValid_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // source presentation
  // ----------------------------------------------------------------------
  // arbitration lives elsewhere; a disabled source is masked here
  ipf_src_gate #(
    .NumSrc(`IPF_NUM_SRC)
  ) u_gate (
    .clk(clk),
    .rst_n(rst_n),
    .srcPend(srcPend),
    .prio(fldPrio),
    .req_q(srcReq),
    .anyReq_q(anyReq)
  );

  // ----------------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = rData_q;

endmodule : ipf_prio_regs

/* rtl/ipf_src_gate.sv */
// ipf_src_gate.sv: presents pending sources with their priority level
// assumes: srcPend comes from logic on clk, so it is not synchronised
`timescale 1ns/1ns
`include "ipf_cfg.svh"

module ipf_src_gate
  import ipf_pkg::*;
#(
  parameter int NumSrc = `IPF_NUM_SRC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NumSrc-1:0] srcPend,
  input wire ipf_prio_t [NumSrc-1:0] prio,
  output ipf_req_t [NumSrc-1:0] req_q,
  output logic anyReq_q
);

  if (NumSrc < 1)
  begin : g_check
    $error("ipf_src_gate: NumSrc must be at least one");
  end

  logic [NumSrc-1:0] live;

  // --------------------------------------------------------------------
  // gating
  // --------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < NumSrc; i++)
      live[i] = srcPend[i] && (prio[i] != `IPF_PRIO_OFF);
  end

  // level passes unchanged: code n is level n, 7 highest
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_q <= '0;
      anyReq_q <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NumSrc; i++)
      begin
        req_q[i].valid <= live[i];
        req_q[i].level <= live[i] ? prio[i] : `IPF_PRIO_OFF;
      end
      anyReq_q <= |live;
    end
  end

endmodule : ipf_src_gate

/* verif/ipf_prio_regs_sva.sv */
// ipf_prio_regs_sva.sv: port assertions for the priority field bank
// assumes: bound to ipf_prio_regs, one clock, async active-low reset
`timescale 1ns/1ns

module ipf_prio_regs_sva import ipf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [3:0] srcPend,
  input wire ipf_prio_t [3:0] srcPriority,
  input wire ipf_req_t [3:0] srcReq,
  input wire logic anyReq
);
  logic [3:0] reqV;
  logic [3:0] pendOn;
  logic arTake;
  assign arTake = s_axi_arvalid && s_axi_arready;
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      reqV[i] = srcReq[i].valid;
      pendOn[i] = srcPend[i] && (srcPriority[i] != 3'h0);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rd_ext1;
    arTake && s_axi_araddr[7:2] == 6'h00 |=> s_axi_rvalid
      && s_axi_rdata == {29'h0, $past(srcPriority[0])};
  endproperty
  a_rd_ext1: assert property (p_rd_ext1)
    else $error("ext1 read data wrong");
  property p_rd_ser2;
    arTake && s_axi_araddr[7:2] == 6'h01 |=> s_axi_rvalid
      && s_axi_rdata == {17'h0, $past(srcPriority[3]), 1'b0,
      $past(srcPriority[2]), 1'b0, $past(srcPriority[1]), 4'h0};
  endproperty
  a_rd_ser2: assert property (p_rd_ser2)
    else $error("second register read data wrong");
  property p_rd_unm;
    arTake && s_axi_araddr[7:2] > 6'h01 |=> s_axi_rvalid
      && s_axi_rdata == 32'h0 && s_axi_rresp == 2'h3;
  endproperty
  a_rd_unm: assert property (p_rd_unm)
    else $error("unmapped read answer wrong");
  property p_req_valid;
    reqV == $past(pendOn);
  endproperty
  a_req_valid: assert property (p_req_valid)
    else $error("request valid does not follow pending and field");
  property p_req_level(k);
    reqV[k] |-> srcReq[k].level == $past(srcPriority[k]);
  endproperty
  for (genvar i = 0; i < 4; i++)
  begin : g_lvl
    a_req_level: assert property (p_req_level(i))
      else $error("request level differs from field");
  end
  property p_any;
    anyReq == (|reqV);
  endproperty
  a_any: assert property (p_any)
    else $error("any request flag wrong");
  property p_prio_hold;
    !s_axi_bvalid |=> $stable(srcPriority);
  endproperty
  a_prio_hold: assert property (p_prio_hold)
    else $error("field changed without a write");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write response late");
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write response dropped early");
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse)
    else $error("write ready high while response pending");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse)
    else $error("read ready high while read data pending");
  c_slow_b: cover property (s_axi_bvalid && !s_axi_bready);
  c_req: cover property (anyReq && !reqV[1]);
  c_unm: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule : ipf_prio_regs_sva

bind ipf_prio_regs ipf_prio_regs_sva u_sva (.clk, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .srcPend, .srcPriority,
  .srcReq, .anyReq);

/* verif/ipf_prio_regs_tb.sv */
// ipf_prio_regs_tb.sv: self-checking bench for the priority field bank
// assumes: package, design and checker compiled before this file
`timescale 1ns/1ns

module ipf_prio_regs_tb import ipf_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [3:0] srcPend = 4'h0;
  ipf_prio_t [3:0] srcPriority;
  ipf_req_t [3:0] srcReq;
  logic anyReq;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  ipf_prio_regs dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .srcPend, .srcPriority, .srcReq, .anyReq);

  initial forever #4 clk = ~clk;

  // ----------------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // hold keeps bready low for a few edges to exercise a stalled response
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input int hold, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (hold == 0);
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
      if (n >= hold) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr_chk

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd_chk

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk({20'h0, srcPriority}, 32'h0000_0924);
    rd_chk(8'h00, 32'h0000_0004, 2'h0);
    rd_chk(8'h04, 32'h0000_4440, 2'h0);
    $display("t_reset done");
  endtask : t_reset

  // every code in every field, with ones written to the unused bits except bits 2..0 of the second register
  task automatic t_walk;
    logic [2:0] v;
    for (int c = 0; c < 8; c++)
    begin
      v = c[2:0];
      wr_chk(8'h00, 32'hFFFF_FFF8 | v, 4'hF, 0, 2'h0);
      rd_chk(8'h00, {29'h0, v}, 2'h0);
      wr_chk(8'h04, 32'hFFFF_8888 | {v, 1'b0, v, 1'b0, v, 4'h0}, 4'hF, 0,
        2'h0);
      rd_chk(8'h04, {17'h0, v, 1'b0, v, 1'b0, v, 4'h0}, 2'h0);
      chk({20'h0, srcPriority}, {20'h0, v, v, v, v});
    end
    $display("t_walk done");
  endtask : t_walk

  task automatic t_strobe;
    wr_chk(8'h04, 32'h0, 4'h1, 0, 2'h0);
    rd_chk(8'h04, 32'h0000_7700, 2'h0);
    wr_chk(8'h04, 32'h0, 4'h2, 0, 2'h0);
    rd_chk(8'h04, 32'h0, 2'h0);
    wr_chk(8'h00, 32'h0, 4'hE, 0, 2'h0);
    rd_chk(8'h00, 32'h0000_0007, 2'h0);
    $display("t_strobe done");
  endtask : t_strobe

  task automatic t_unmapped;
    wr_chk(8'h08, 32'hFFFF_FFFF, 4'hF, 3, 2'h3);
    rd_chk(8'h08, 32'h0, 2'h3);
    rd_chk(8'h00, 32'h0000_0007, 2'h0);
    rd_chk(8'h04, 32'h0, 2'h0);
    $display("t_unmapped done");
  endtask : t_unmapped

  // ext2 disabled while pending: it must never be presented
  task automatic t_gate;
    wr_chk(8'h00, 32'h0000_0001, 4'hF, 0, 2'h0);
    wr_chk(8'h04, 32'h0000_7500, 4'hF, 0, 2'h0);
    srcPend <= 4'hF;
    repeat (3) @(posedge clk);
    chk({16'h0, srcReq}, 32'h0000_FD09);
    chk({31'h0, anyReq}, 32'h1);
    srcPend <= 4'h2;
    repeat (3) @(posedge clk);
    chk({31'h0, anyReq}, 32'h0);
    chk({31'h0, srcReq[1].valid}, 32'h0);
    srcPend <= 4'h0;
    @(posedge clk);
    $display("t_gate done");
  endtask : t_gate

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ceiling well above the roughly 160 cycles the scenarios need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_walk();
    t_strobe();
    t_unmapped();
    t_gate();
    results();
  end
endmodule : ipf_prio_regs_tb
